// ### pkg/mbs_pkg.sv
// shared constants and types for the serial register responder
`default_nettype none
package mbs_pkg;
	// ----------------------------------------
	// function and exception codes
	// ----------------------------------------
	localparam logic [7:0] FC_RD_HOLD = 8'h03; // read holding registers
	localparam logic [7:0] FC_RD_IN = 8'h04; // read input registers
	localparam logic [7:0] FC_WR_ONE = 8'h06; // preset single register
	localparam logic [7:0] EXC_FLAG = 8'h80; // added to function code on error
	localparam logic [7:0] EXC_NAK = 8'h07; // the only exception code sent

	// ----------------------------------------
	// frame layout and limits
	// ----------------------------------------
	localparam logic [3:0] REQ_LEN = 4'h8; // id, fc, addr(2), qty/data(2), crc(2)
	localparam logic [2:0] IDX_ID = 3'h0; // byte positions in a request
	localparam logic [2:0] IDX_FC = 3'h1;
	localparam logic [2:0] IDX_AHI = 3'h2;
	localparam logic [2:0] IDX_ALO = 3'h3;
	localparam logic [2:0] IDX_DHI = 3'h4;
	localparam logic [2:0] IDX_DLO = 3'h5;
	localparam logic [15:0] MAX_QTY = 16'h007D; // largest read that fits a reply
	localparam logic [1:0] HDR_LAST_SHORT = 2'h2; // id, fc, count or exception
	localparam logic [1:0] HDR_LAST_LONG = 2'h3; // id, fc, addr hi, addr lo

	// ----------------------------------------
	// checksum
	// ----------------------------------------
	localparam logic [15:0] CRC_INIT = 16'hFFFF; // preset of the check register
	localparam logic [15:0] CRC_POLY = 16'hA001; // reflected polynomial

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [3:0] {
		S_RX, S_EVAL, S_WRITE, S_HDR, S_FETCH, S_DHI, S_DLO, S_CRCL, S_CRCH
	} mbs_state_t;

	typedef struct packed {
		logic we; // 1 = write, 0 = read
		logic input_space; // 1 = input registers, 0 = holding registers
		logic [15:0] addr; // register number
		logic [15:0] wdata; // value to write
	} mbs_reg_cmd_t;
endpackage
`default_nettype wire

// ### rtl/mbs_crc_step.sv
// one byte step of the 16-bit frame check
`timescale 1ns/1ps
`default_nettype none
module mbs_crc_step
	import mbs_pkg::*;
(
	input wire logic [15:0] crc_in, // running check value
	input wire logic [7:0] data_in, // byte folded in
	output logic [15:0] crc_out // check value after the byte
);
	// ----------------------------------------
	// bitwise shift, lsb first
	// ----------------------------------------
	always_comb begin
		logic [15:0] c;
		c = crc_in ^ {8'h00, data_in};
		for (int i = 0; i < 8; i++) begin
			if (c[0]) begin
				c = (c >> 1) ^ CRC_POLY;
			end else begin
				c = c >> 1;
			end
		end
		crc_out = c;
	end
endmodule
`default_nettype wire

// ### rtl/mbs_responder.sv
// serial register request interpreter and reply builder
//
// Functional notes
// - protocol served only in RS-485 mode
// - read reply: id, fc, count, words, CRC
// - error reply: id, fc plus 80H, code, CRC
// - exception code is always 07
// - any communications problem gives exception 07
// - written values returned, master compares them
`timescale 1ns/1ps
`default_nettype none
module mbs_responder
	import mbs_pkg::*;
(
	input wire logic clk, // 50 MHz system clock
	input wire logic nrst, // async reset, active low
	input wire logic rs485_mode, // pin: serial port in RS-485 mode
	input wire logic [7:0] unit_id, // own station address
	input wire logic rx_valid, // received byte strobe
	input wire logic [7:0] rx_data, // received byte
	input wire logic rx_gap, // end-of-frame silence pulse
	output logic tx_valid, // byte offered to transmitter
	output logic [7:0] tx_data, // byte offered
	input wire logic tx_ready, // transmitter takes byte
	output logic tx_drive_en, // line driver enable while replying
	output logic reg_req, // register access request, held until ack
	output mbs_reg_cmd_t reg_cmd, // access kind, address, write value
	input wire logic reg_ack, // access done
	input wire logic [15:0] reg_rdata // read value, valid with ack
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic mode_s1_q, mode_s2_q; // mode pin synchroniser
	mbs_state_t state_q, state_d; // sequencer
	logic [7:0] buf_q [0:7]; // request bytes
	logic [7:0] buf_d [0:7];
	logic [3:0] cnt_q, cnt_d; // bytes stored
	logic ovf_q, ovf_d; // more bytes than a request holds
	logic [15:0] crc_rx_q, crc_rx_d; // check over whole request
	logic [15:0] crc_tx_q, crc_tx_d; // check over reply so far
	logic exc_q, exc_d; // reply is an error reply
	logic [7:0] fc_q, fc_d; // function code of request
	logic [15:0] addr_q, addr_d; // current register number
	logic [7:0] words_q, words_d; // words still to send
	logic [15:0] word_q, word_d; // word being sent
	logic [1:0] hdr_idx_q, hdr_idx_d; // header byte index
	logic tx_valid_q, tx_valid_d; // offer pending
	logic [7:0] tx_data_q, tx_data_d; // offered byte
	logic [15:0] crc_rx_nx, crc_tx_nx; // check values after one byte
	logic [15:0] qty; // quantity or write value field

	assign qty = {buf_q[IDX_DHI], buf_q[IDX_DLO]};

	// ----------------------------------------
	// checksum steps
	// ----------------------------------------
	mbs_crc_step u_crc_rx (
		.crc_in(crc_rx_q),
		.data_in(rx_data),
		.crc_out(crc_rx_nx)
	);
	mbs_crc_step u_crc_tx (
		.crc_in(crc_tx_q),
		.data_in(tx_data_q),
		.crc_out(crc_tx_nx)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;
	assign tx_drive_en = (state_q != S_RX) && (state_q != S_EVAL);
	assign reg_req = (state_q == S_WRITE) || (state_q == S_FETCH);
	assign reg_cmd.we = (state_q == S_WRITE);
	assign reg_cmd.input_space = (fc_q == FC_RD_IN);
	assign reg_cmd.addr = addr_q;
	assign reg_cmd.wdata = qty;

	// mode pin comes from outside, two flops before use
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_s1_q <= 1'b0;
			mode_s2_q <= 1'b0;
		end else begin
			mode_s1_q <= rs485_mode;
			mode_s2_q <= mode_s1_q;
		end
	end

	// ----------------------------------------
	// sequencer next values
	// ----------------------------------------
	always_comb begin
		logic [7:0] fc;
		logic rd, wr, bad, send, adv;
		logic [7:0] byte_now;
		fc = buf_q[IDX_FC];
		rd = (fc == FC_RD_HOLD) || (fc == FC_RD_IN);
		wr = (fc == FC_WR_ONE);
		bad = 1'b0;
		send = 1'b0;
		adv = 1'b0;
		byte_now = 8'h00;
		state_d = state_q;
		buf_d = buf_q;
		cnt_d = cnt_q;
		ovf_d = ovf_q;
		crc_rx_d = crc_rx_q;
		crc_tx_d = crc_tx_q;
		exc_d = exc_q;
		fc_d = fc_q;
		addr_d = addr_q;
		words_d = words_q;
		word_d = word_q;
		hdr_idx_d = hdr_idx_q;
		tx_valid_d = tx_valid_q;
		tx_data_d = tx_data_q;
		// byte to offer in each sending state
		case (state_q)
			S_HDR: begin
				send = 1'b1;
				case (hdr_idx_q)
					2'h0: byte_now = unit_id;
					2'h1: byte_now = exc_q ? (fc_q | EXC_FLAG) : fc_q;
					2'h2: begin
						if (exc_q) begin
							byte_now = EXC_NAK;
						end else if (fc_q == FC_WR_ONE) begin
							byte_now = addr_q[15:8];
						end else begin
							byte_now = {words_q[6:0], 1'b0};
						end
					end
					default: byte_now = addr_q[7:0];
				endcase
			end
			S_DHI: begin
				send = 1'b1;
				byte_now = word_q[15:8];
			end
			S_DLO: begin
				send = 1'b1;
				byte_now = word_q[7:0];
			end
			S_CRCL: begin
				send = 1'b1;
				byte_now = crc_tx_q[7:0];
			end
			S_CRCH: begin
				send = 1'b1;
				byte_now = crc_tx_q[15:8];
			end
			default: begin
				send = 1'b0;
			end
		endcase
		// offer one byte, fold it into the check once taken, except the two check bytes
		if (send) begin
			if (!tx_valid_q) begin
				tx_valid_d = 1'b1;
				tx_data_d = byte_now;
			end else if (tx_ready) begin
				tx_valid_d = 1'b0;
				adv = 1'b1;
				if ((state_q != S_CRCL) && (state_q != S_CRCH)) begin
					crc_tx_d = crc_tx_nx;
				end
			end
		end
		case (state_q)
			// collect request bytes; ignored outside RS-485 mode
			S_RX: begin
				if (!mode_s2_q) begin
					cnt_d = 4'h0;
					ovf_d = 1'b0;
					crc_rx_d = CRC_INIT;
				end else begin
					if (rx_valid) begin
						crc_rx_d = crc_rx_nx;
						if (cnt_q < REQ_LEN) begin
							buf_d[cnt_q[2:0]] = rx_data;
							cnt_d = 4'(cnt_q + 4'h1);
						end else begin
							ovf_d = 1'b1;
						end
					end
					if (rx_gap) begin
						state_d = S_EVAL;
					end
				end
			end
			// judge the request; any problem turns into exception 07
			S_EVAL: begin
				cnt_d = 4'h0;
				ovf_d = 1'b0;
				crc_rx_d = CRC_INIT;
				crc_tx_d = CRC_INIT;
				hdr_idx_d = 2'h0;
				if ((cnt_q == 4'h0) || (buf_q[IDX_ID] != unit_id)) begin
					state_d = S_RX; // not addressed to this unit
				end else begin
					bad = ovf_q || (cnt_q != REQ_LEN) || (crc_rx_q != 16'h0000) ||
						!(rd || wr) || (rd && ((qty == 16'h0000) || (qty > MAX_QTY)));
					exc_d = bad;
					fc_d = fc;
					addr_d = {buf_q[IDX_AHI], buf_q[IDX_ALO]};
					if (bad) begin
						words_d = 8'h00;
						state_d = S_HDR;
					end else if (wr) begin
						words_d = 8'h01; // read back the written register
						state_d = S_WRITE;
					end else begin
						words_d = qty[7:0];
						state_d = S_HDR;
					end
				end
			end
			// write the register, then reply
			S_WRITE: begin
				if (reg_ack) begin
					state_d = S_HDR;
				end
			end
			// header bytes
			S_HDR: begin
				if (adv) begin
					if (hdr_idx_q == ((exc_q || (fc_q != FC_WR_ONE)) ? HDR_LAST_SHORT
							: HDR_LAST_LONG)) begin
						hdr_idx_d = 2'h0;
						state_d = (words_q != 8'h00) ? S_FETCH : S_CRCL;
					end else begin
						hdr_idx_d = 2'(hdr_idx_q + 2'h1);
					end
				end
			end
			// fetch one register word
			S_FETCH: begin
				if (reg_ack) begin
					word_d = reg_rdata;
					state_d = S_DHI;
				end
			end
			S_DHI: begin
				if (adv) begin
					state_d = S_DLO;
				end
			end
			S_DLO: begin
				if (adv) begin
					words_d = 8'(words_q - 8'h01);
					addr_d = 16'(addr_q + 16'h0001);
					state_d = (words_q == 8'h01) ? S_CRCL : S_FETCH;
				end
			end
			S_CRCL: begin
				if (adv) begin
					state_d = S_CRCH;
				end
			end
			S_CRCH: begin
				if (adv) begin
					state_d = S_RX;
				end
			end
			default: begin
				state_d = S_RX;
			end
		endcase
	end

	// ----------------------------------------
	// sequencer registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_RX;
			for (int i = 0; i < 8; i++) begin
				buf_q[i] <= 8'h00;
			end
			cnt_q <= 4'h0;
			ovf_q <= 1'b0;
			crc_rx_q <= CRC_INIT;
			crc_tx_q <= CRC_INIT;
			exc_q <= 1'b0;
			fc_q <= 8'h00;
			addr_q <= 16'h0000;
			words_q <= 8'h00;
			word_q <= 16'h0000;
			hdr_idx_q <= 2'h0;
			tx_valid_q <= 1'b0;
			tx_data_q <= 8'h00;
		end else begin
			state_q <= state_d;
			buf_q <= buf_d;
			cnt_q <= cnt_d;
			ovf_q <= ovf_d;
			crc_rx_q <= crc_rx_d;
			crc_tx_q <= crc_tx_d;
			exc_q <= exc_d;
			fc_q <= fc_d;
			addr_q <= addr_d;
			words_q <= words_d;
			word_q <= word_d;
			hdr_idx_q <= hdr_idx_d;
			tx_valid_q <= tx_valid_d;
			tx_data_q <= tx_data_d;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_mode_gate;
		(state_q == S_RX && !mode_s2_q) |=> (state_q == S_RX && cnt_q == 4'h0);
	endproperty
	a_mode_gate: assert property (p_mode_gate) else $error("frame taken outside RS-485");

	property p_byte_count;
		(state_q == S_HDR && hdr_idx_q == 2'h2 && tx_valid_q && !exc_q && fc_q != FC_WR_ONE)
			|-> (tx_data_q == {qty[6:0], 1'b0});
	endproperty
	a_byte_count: assert property (p_byte_count) else $error("byte count not twice qty");

	property p_exc_fc;
		(state_q == S_HDR && hdr_idx_q == 2'h1 && tx_valid_q && exc_q)
			|-> (tx_data_q == (buf_q[IDX_FC] | EXC_FLAG));
	endproperty
	a_exc_fc: assert property (p_exc_fc) else $error("error reply lacks 80H flag");

	property p_exc_code;
		(state_q == S_HDR && hdr_idx_q == 2'h2 && tx_valid_q && exc_q) |-> (tx_data_q == EXC_NAK);
	endproperty
	a_exc_code: assert property (p_exc_code) else $error("exception code not 07");

	sequence s_bad_crc;
		state_q == S_EVAL && cnt_q != 4'h0 && buf_q[IDX_ID] == unit_id && crc_rx_q != 16'h0000;
	endsequence
	property p_bad_crc_nak;
		s_bad_crc |=> (exc_q && state_q == S_HDR) ##1 (tx_valid_q && hdr_idx_q == 2'h0);
	endproperty
	a_bad_crc_nak: assert property (p_bad_crc_nak) else $error("bad checksum not refused");

	sequence s_wr_done;
		state_q == S_WRITE && reg_ack;
	endsequence
	property p_write_echo;
		s_wr_done |=> (state_q == S_HDR && words_q == 8'h01 && !exc_q && !reg_req);
	endproperty
	a_write_echo: assert property (p_write_echo) else $error("write not read back");

	sequence s_crc_lo_taken;
		state_q == S_CRCL && tx_valid_q && tx_ready && tx_data_q == crc_tx_q[7:0];
	endsequence
	property p_crc_order;
		s_crc_lo_taken |=> (state_q == S_CRCH && !tx_valid_q) ##1
			(tx_valid_q && tx_data_q == crc_tx_q[15:8]);
	endproperty
	a_crc_order: assert property (p_crc_order) else $error("checksum order wrong");
endmodule
`default_nettype wire

// ### testbench/mbs_master.sv
// master-side model: sends requests, gathers and judges replies
`timescale 1ns/1ps
`default_nettype none
module mbs_master
	import mbs_pkg::*;
(
	input wire logic clk, // system clock
	output logic rx_valid, // byte strobe toward the responder
	output logic [7:0] rx_data, // byte toward the responder
	output logic rx_gap, // end-of-frame silence pulse
	input wire logic tx_valid, // reply byte offered
	input wire logic [7:0] tx_data, // reply byte
	input wire logic tx_drive_en, // responder owns the line
	output logic tx_ready // take reply byte
);
	// ----------------------------------------
	// reply capture
	// ----------------------------------------
	logic [7:0] got[$]; // reply bytes taken so far
	logic stall = 1'b0; // 1 = take replies slowly
	logic drive_bad = 1'b0; // byte offered with line driver off
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_gap = 1'b0;
		tx_ready = 1'b1;
	end
	// slow mode halves the take rate so the responder must hold its byte
	always @(negedge clk) begin
		tx_ready <= stall ? ~tx_ready : 1'b1;
	end
	// gather every byte taken, note a byte sent while the driver is off
	always @(posedge clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			got.push_back(tx_data);
			if (tx_drive_en !== 1'b1) drive_bad <= 1'b1;
		end
	end
	// ----------------------------------------
	// frame check and transfers
	// ----------------------------------------
	// reflected 16-bit check, preset all ones
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
	// one byte a cycle, gap with the last; idle data shows the inverse
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			@(negedge clk);
			rx_valid = 1'b1;
			rx_data = q[i];
			rx_gap = (i == q.size() - 1);
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_gap = 1'b0;
		rx_data = ~rx_data;
	endtask
	// wait for n reply bytes within a bound, then judge the reply
	task automatic await(input int n, output bit tmo, output bit crc_ok, output bit ovf);
		for (int k = 0; k < 400 && got.size() < n; k++) @(negedge clk);
		tmo = (got.size() < n);
		repeat (20) @(negedge clk);
		ovf = (got.size() > n);
		crc_ok = (crc16(got) == 16'h0000);
	endtask
endmodule
`default_nettype wire

// ### testbench/modbus_slave_responder_bench.sv
// self-checking bench for the serial register responder
`timescale 1ns/1ps
`default_nettype none
module modbus_slave_responder_bench;
	import mbs_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clk, nrst, rs485_mode, rx_valid, rx_gap, tx_valid, tx_ready, tx_drive_en;
	logic reg_req, reg_ack;
	logic [7:0] unit_id, rx_data, tx_data;
	logic [15:0] reg_rdata;
	mbs_reg_cmd_t reg_cmd;
	logic [15:0] regs [0:15]; // holding 0-7, input 8-15
	int err_count = 0;
	int tests_run = 0;
	mbs_responder u_mbs_responder (.clk(clk), .nrst(nrst), .rs485_mode(rs485_mode),
		.unit_id(unit_id), .rx_valid(rx_valid), .rx_data(rx_data), .rx_gap(rx_gap),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.tx_drive_en(tx_drive_en), .reg_req(reg_req), .reg_cmd(reg_cmd),
		.reg_ack(reg_ack), .reg_rdata(reg_rdata));
	mbs_master u_mbs_master (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_gap(rx_gap), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_drive_en(tx_drive_en), .tx_ready(tx_ready));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// register store answers each request once; idle data is scrambled
	always @(negedge clk) begin
		reg_ack <= 1'b0;
		reg_rdata <= ~reg_rdata;
		if (reg_req === 1'b1 && reg_ack !== 1'b1) begin
			reg_ack <= 1'b1;
			reg_rdata <= regs[{reg_cmd.input_space, reg_cmd.addr[2:0]}];
			if (reg_cmd.we === 1'b1) regs[{1'b0, reg_cmd.addr[2:0]}] <= reg_cmd.wdata;
		end
	end
	// ----------------------------------------
	// checking
	// ----------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (err_count == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// send a request with check bytes, compare the whole reply with exp
	task automatic xact(input logic [7:0] req[$], input bit bad, input logic [7:0] exp[$]);
		logic [15:0] c;
		bit tmo, ok, ovf;
		c = u_mbs_master.crc16(req);
		if (bad) c = ~c;
		req.push_back(c[7:0]);
		req.push_back(c[15:8]);
		if (exp.size() > 0) begin
			c = u_mbs_master.crc16(exp);
			exp.push_back(c[7:0]);
			exp.push_back(c[15:8]);
		end
		u_mbs_master.got.delete();
		u_mbs_master.send(req);
		u_mbs_master.await(exp.size(), tmo, ok, ovf);
		check(tmo, 1'b0);
		check(ovf, 1'b0);
		if (exp.size() > 0) check(ok, 1'b1);
		foreach (exp[i])
			if (i < u_mbs_master.got.size()) check(u_mbs_master.got[i], exp[i]);
		check(tx_drive_en, 1'b0);
		check(u_mbs_master.drive_bad, 1'b0);
		if (tmo) tally_and_finish();
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_read();
		xact('{8'h01, 8'h04, 8'h00, 8'h02, 8'h00, 8'h02}, 0,
			'{8'h01, 8'h04, 8'h04, 8'h06, 8'h23, 8'h00, 8'hED});
		// master side range check of the first returned input word
		check({u_mbs_master.got[3], u_mbs_master.got[4]} <= 16'h0FFF, 1'b1);
		u_mbs_master.stall = 1'b1;
		xact('{8'h01, 8'h03, 8'h00, 8'h06, 8'h00, 8'h02}, 0,
			'{8'h01, 8'h03, 8'h04, 8'h5A, 8'h5A, 8'hBE, 8'hEF});
		u_mbs_master.stall = 1'b0;
	endtask
	task automatic t_write();
		xact('{8'h01, 8'h06, 8'h00, 8'h05, 8'h12, 8'h34}, 0,
			'{8'h01, 8'h06, 8'h00, 8'h05, 8'h12, 8'h34});
		xact('{8'h01, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01}, 0,
			'{8'h01, 8'h03, 8'h02, 8'h12, 8'h34});
	endtask
	task automatic t_errors();
		logic [7:0] fcs[$];
		fcs = '{8'h01, 8'h05, 8'h10};
		xact('{8'h01, 8'h04, 8'h00, 8'h02, 8'h00, 8'h02}, 1, '{8'h01, 8'h84, 8'h07});
		foreach (fcs[i]) xact('{8'h01, fcs[i], 8'h00, 8'h00, 8'h00, 8'h01}, 0,
			'{8'h01, fcs[i] | 8'h80, 8'h07});
		xact('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, 0, '{8'h01, 8'h83, 8'h07});
		xact('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h7E}, 0, '{8'h01, 8'h84, 8'h07});
		xact('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00}, 0,
			'{8'h01, 8'h84, 8'h07});
		xact('{8'h01, 8'h04, 8'h00, 8'h00, 8'h01}, 0, '{8'h01, 8'h84, 8'h07});
	endtask
	task automatic t_silent();
		xact('{8'h02, 8'h04, 8'h00, 8'h02, 8'h00, 8'h01}, 0, '{});
		rs485_mode = 1'b0;
		repeat (4) @(negedge clk);
		xact('{8'h01, 8'h04, 8'h00, 8'h02, 8'h00, 8'h01}, 0, '{});
		rs485_mode = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	initial begin
		nrst = 1'b0;
		rs485_mode = 1'b1;
		unit_id = 8'h01;
		reg_ack = 1'b0;
		reg_rdata = 16'h0000;
		foreach (regs[i]) regs[i] = 16'h5A5A;
		regs[7] = 16'hBEEF;
		regs[10] = 16'h0623;
		regs[11] = 16'h00ED;
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		t_read();
		t_write();
		t_errors();
		t_silent();
		tally_and_finish();
	end
endmodule
`default_nettype wire
